// ---- src/dcache_peek.sv ----
// Data cache status and tag readout unit for the processor pipeline
`timescale 1ns/1ps

// How it works
// - A status read adds the modifier to the first source operand and picks the set from sum bits 10..6.
// - A status result holds replacement-order bits in 9..0, dirty bits in 17..10 and zero in 31..18.
// - A status read stalls the issuing pipeline for two cycles and writes back three cycles after issue.
// - Each read uses the tag and status copy of the cache port tied to the issuing slot.
// - A tag read picks the set from sum bits 10..6 and the element from sum bits 13..11.
// - A tag result holds the block's address tag in 21..0 and zero in 31..22.
// - A tag read inserts no stall cycles.
// - With a guard present, the destination is written only when the guard's least significant bit is 1.
module dcache_peek (
    input  wire logic                                 CLK,
    input  wire logic                                 RST_N,
    input  wire logic                                 STATUS_REQ,
    input  wire logic                                 TAG_REQ,
    input  wire logic                                 REQ_PORT,
    input  wire logic [dcache_peek_pkg::DATA_W-1:0]   FIRST_SOURCE_OPERAND,
    input  wire logic [dcache_peek_pkg::MOD_W-1:0]    MODIFIER,
    input  wire logic                                 GUARD_PRESENT,
    input  wire logic [dcache_peek_pkg::DATA_W-1:0]   GUARD_VALUE,
    output logic                                      P0_SET_EN,
    output logic [dcache_peek_pkg::SET_W-1:0]         P0_SET,
    output logic [dcache_peek_pkg::ELEM_W-1:0]        P0_ELEM,
    input  wire logic [dcache_peek_pkg::REPL_W-1:0]   P0_REPL,
    input  wire logic [dcache_peek_pkg::DIRTY_W-1:0]  P0_DIRTY,
    input  wire logic [dcache_peek_pkg::TAG_W-1:0]    P0_TAG,
    output logic                                      P1_SET_EN,
    output logic [dcache_peek_pkg::SET_W-1:0]         P1_SET,
    output logic [dcache_peek_pkg::ELEM_W-1:0]        P1_ELEM,
    input  wire logic [dcache_peek_pkg::REPL_W-1:0]   P1_REPL,
    input  wire logic [dcache_peek_pkg::DIRTY_W-1:0]  P1_DIRTY,
    input  wire logic [dcache_peek_pkg::TAG_W-1:0]    P1_TAG,
    output logic                                      STALL,
    output logic                                      DEST_WE,
    output logic [dcache_peek_pkg::DATA_W-1:0]        DEST_DATA
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        dcache_peek_pkg::peek_state_t             state;
        logic [1:0]                               cnt;
        logic                                     port;
        logic                                     enable;
        logic [dcache_peek_pkg::SET_W-1:0]        set;
        logic                                     we;
        logic [dcache_peek_pkg::DATA_W-1:0]       data;
    } peek_regs_t;

    peek_regs_t r;
    peek_regs_t next_r;

    logic [dcache_peek_pkg::DATA_W-1:0] addr;
    logic                               enable_now;
    logic [dcache_peek_pkg::TAG_W-1:0]  tag_sel;
    logic [dcache_peek_pkg::REPL_W-1:0] repl_sel;
    logic [dcache_peek_pkg::DIRTY_W-1:0] dirty_sel;
    logic                               busy;

    // ------------------------------------------------------------
    // Address and array lookup
    // ------------------------------------------------------------
    // Modifier is sign-extended before the add
    assign addr = FIRST_SOURCE_OPERAND
                + {{(dcache_peek_pkg::DATA_W - dcache_peek_pkg::MOD_W){MODIFIER[dcache_peek_pkg::MOD_W-1]}},
                   MODIFIER};
    assign enable_now = !GUARD_PRESENT || GUARD_VALUE[0];
    assign busy       = (r.state != dcache_peek_pkg::ST_IDLE);

    // ------------------------------------------------------------
    // Issue decode
    // ------------------------------------------------------------
    logic                                 issuing;
    logic                                 status_issue;
    logic                                 tag_issue;

    // Status wins when both requests arrive in the same idle cycle
    assign issuing      = !busy && (TAG_REQ || STATUS_REQ);
    assign status_issue = !busy && STATUS_REQ;
    assign tag_issue    = !busy && !STATUS_REQ && TAG_REQ;

    // ------------------------------------------------------------
    // Per-port array access
    // ------------------------------------------------------------
    // Arrays are addressed combinationally while a tag read issues, and held during a status read
    logic                                 port_en    [2];
    logic [dcache_peek_pkg::SET_W-1:0]    port_set   [2];
    logic [dcache_peek_pkg::ELEM_W-1:0]   port_elem  [2];
    logic [dcache_peek_pkg::TAG_W-1:0]    port_tag   [2];
    logic [dcache_peek_pkg::REPL_W-1:0]   port_repl  [2];
    logic [dcache_peek_pkg::DIRTY_W-1:0]  port_dirty [2];

    genvar g;
    // One copy of the lookup per cache port
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_port
            logic mine_busy;
            logic mine_issue;

            assign mine_busy    = busy && (r.port == 1'(g));
            assign mine_issue   = issuing && (REQ_PORT == 1'(g));
            assign port_en[g]   = mine_busy || mine_issue;
            assign port_set[g]  = issuing ? addr[dcache_peek_pkg::SET_HI:dcache_peek_pkg::SET_LO] : r.set;
            assign port_elem[g] = addr[dcache_peek_pkg::ELEM_HI:dcache_peek_pkg::ELEM_LO];
        end
    endgenerate

    assign P0_SET_EN = port_en[0];
    assign P1_SET_EN = port_en[1];
    assign P0_SET    = port_set[0];
    assign P1_SET    = port_set[1];
    assign P0_ELEM   = port_elem[0];
    assign P1_ELEM   = port_elem[1];

    assign port_tag[0]   = P0_TAG;
    assign port_tag[1]   = P1_TAG;
    assign port_repl[0]  = P0_REPL;
    assign port_repl[1]  = P1_REPL;
    assign port_dirty[0] = P0_DIRTY;
    assign port_dirty[1] = P1_DIRTY;

    // Tag comes from the issuing port; status from the port latched at issue
    assign tag_sel   = port_tag[REQ_PORT];
    assign repl_sel  = port_repl[r.port];
    assign dirty_sel = port_dirty[r.port];

    // ------------------------------------------------------------
    // Result words
    // ------------------------------------------------------------
    logic [dcache_peek_pkg::DATA_W-1:0]   status_word;
    logic [dcache_peek_pkg::DATA_W-1:0]   tag_word;

    assign status_word = {{(dcache_peek_pkg::DATA_W - dcache_peek_pkg::REPL_W
                            - dcache_peek_pkg::DIRTY_W){1'b0}},
                          dirty_sel, repl_sel};
    assign tag_word    = {{(dcache_peek_pkg::DATA_W - dcache_peek_pkg::TAG_W){1'b0}},
                          tag_sel};

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_r    = r;
        next_r.we = 1'b0;

        case (r.state)
            dcache_peek_pkg::ST_IDLE: begin
                next_r.cnt = 2'h0;
                if (status_issue) begin
                    next_r.state  = dcache_peek_pkg::ST_STALL;
                    next_r.cnt    = 2'h1;
                    next_r.port   = REQ_PORT;
                    next_r.enable = enable_now;
                    next_r.set    = addr[dcache_peek_pkg::SET_HI:dcache_peek_pkg::SET_LO];
                end else if (tag_issue) begin
                    next_r.we = enable_now;
                    if (enable_now) begin
                        next_r.data = tag_word;
                    end
                end
            end

            dcache_peek_pkg::ST_STALL: begin
                if (r.cnt == dcache_peek_pkg::STALL_LAST) begin
                    // Capture on the last stall edge so the write lands three cycles after issue
                    next_r.state = dcache_peek_pkg::ST_DONE;
                    next_r.we    = r.enable;
                    if (r.enable) begin
                        next_r.data = status_word;
                    end
                end else begin
                    next_r.cnt = r.cnt + 2'h1;
                end
            end

            dcache_peek_pkg::ST_DONE: begin
                // Write-back cycle; requests offered here are dropped
                next_r.state = dcache_peek_pkg::ST_IDLE;
                next_r.cnt   = 2'h0;
            end

            default: begin
                next_r.state = dcache_peek_pkg::ST_IDLE;
                next_r.cnt   = 2'h0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Whole state is one struct so reset and update cannot drift apart
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            r.state  <= dcache_peek_pkg::ST_IDLE;
            r.cnt    <= 2'h0;
            r.port   <= 1'b0;
            r.enable <= 1'b0;
            r.set    <= '0;
            r.we     <= 1'b0;
            r.data   <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Stall is a pure state decode so the pipeline sees exactly two cycles
    assign STALL     = (r.state == dcache_peek_pkg::ST_STALL);

    // Write strobe and data both come straight from flops
    assign DEST_WE   = r.we;
    assign DEST_DATA = r.data;

endmodule

// ---- inc/dcache_peek_pkg.sv ----
// Constants and types shared by the data cache status and tag readout unit
package dcache_peek_pkg;
    localparam int DATA_W        = 32;
    localparam int MOD_W         = 9;
    localparam int SET_LO        = 6;
    localparam int SET_HI        = 10;
    localparam int SET_W         = 5;
    localparam int ELEM_LO       = 11;
    localparam int ELEM_HI       = 13;
    localparam int ELEM_W        = 3;
    localparam int REPL_W        = 10;
    localparam int DIRTY_W       = 8;
    localparam int TAG_W         = 22;
    localparam int STATUS_STALLS = 2;
    localparam logic [1:0] STALL_LAST = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_STALL = 3'b010,
        ST_DONE  = 3'b100
    } peek_state_t;
endpackage

// ---- sim/dcache_array_model.sv ----
// Behavioural tag and status arrays of one cache port copy
`timescale 1ns/1ps
module dcache_array_model #(parameter logic K = 1'b0) (
    input  wire logic        en,
    input  wire logic [4:0]  set,
    input  wire logic [2:0]  elem,
    output logic      [9:0]  repl,
    output logic      [7:0]  dirty,
    output logic      [21:0] tag
);
    // Each copy holds its own contents; an unselected copy shows inverted data
    always_comb begin
        repl  = {set, set} ^ {10{K ^ !en}};
        dirty = {3'h2, set} ^ {8{K ^ !en}};
        tag   = {K, 3'h0, elem, set, set, set} ^ {22{!en}};
    end
endmodule

// ---- sim/dcache_peek_checker.sv ----
// Assertions on the ports of the data cache readout unit
`timescale 1ns/1ps
module dcache_peek_checker (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        STATUS_REQ,
    input wire logic        TAG_REQ,
    input wire logic        REQ_PORT,
    input wire logic [31:0] FIRST_SOURCE_OPERAND,
    input wire logic [8:0]  MODIFIER,
    input wire logic        GUARD_PRESENT,
    input wire logic [31:0] GUARD_VALUE,
    input wire logic [4:0]  P0_SET,
    input wire logic [2:0]  P0_ELEM,
    input wire logic [21:0] P0_TAG,
    input wire logic        STALL,
    input wire logic        DEST_WE,
    input wire logic [31:0] DEST_DATA
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic [1:0]  cnt;
    logic [31:0] a;
    wire tk = (STATUS_REQ || TAG_REQ) && cnt == 2'h0;
    wire st = tk && STATUS_REQ;
    wire tg = tk && !STATUS_REQ;
    wire ok = !GUARD_PRESENT || GUARD_VALUE[0];
    assign a = FIRST_SOURCE_OPERAND + {{23{MODIFIER[8]}}, MODIFIER};
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            cnt <= 2'h0;
        else
            cnt <= st ? 2'h3 : (cnt != 2'h0 ? cnt - 2'h1 : 2'h0);
    end
    a_status_stall_two: assert property (st |=> STALL [*2] ##1 !STALL)
        else $error("status stall length wrong");
    a_status_result_late: assert property (st && ok |-> ##3 DEST_WE && DEST_DATA[31:18] == 14'h0)
        else $error("status result wrong");
    a_tag_no_stall: assert property (tg |=> !STALL)
        else $error("tag read stalled");
    a_tag_result_value: assert property (tg && ok && !REQ_PORT |=> DEST_WE && DEST_DATA == {10'h0, $past(P0_TAG)})
        else $error("tag result wrong");
    a_guard_status_hold: assert property (st && !ok |-> ##1 (!DEST_WE && $stable(DEST_DATA)) [*3])
        else $error("guarded status wrote");
    a_guard_tag_hold: assert property (tg && !ok |=> !DEST_WE && $stable(DEST_DATA))
        else $error("guarded tag wrote");
    a_set_elem_pick: assert property (tg && !REQ_PORT |-> P0_SET == a[10:6] && P0_ELEM == a[13:11])
        else $error("set or element wrong");
    a_unguarded_write: assert property (tg && !GUARD_PRESENT |=> DEST_WE)
        else $error("unguarded tag not written");
endmodule
bind dcache_peek dcache_peek_checker dcache_peek_checker_inst (.*);

// ---- sim/dcache_peek_tb_top.sv ----
// Self-checking bench for the data cache readout unit
`timescale 1ns/1ps
module dcache_peek_tb_top;
    logic        CLK = 0, RST_N = 0, STATUS_REQ = 0, TAG_REQ = 0, REQ_PORT = 0, GUARD_PRESENT = 0;
    logic [31:0] FIRST_SOURCE_OPERAND = 0, GUARD_VALUE = 0, DEST_DATA, r = 32'h0000_ce8d;
    logic [8:0]  MODIFIER = 0;
    logic        P0_SET_EN, P1_SET_EN, STALL, DEST_WE;
    logic [4:0]  P0_SET, P1_SET;
    logic [2:0]  P0_ELEM, P1_ELEM;
    logic [9:0]  P0_REPL, P1_REPL;
    logic [7:0]  P0_DIRTY, P1_DIRTY;
    logic [21:0] P0_TAG, P1_TAG;
    logic [31:0] q[$];
    int          fail_count = 0, checks = 0;
    always #5 CLK = ~CLK;
    dcache_peek dcache_peek_inst (.*);
    dcache_array_model #(.K(1'b0)) p0_inst (.en(P0_SET_EN), .set(P0_SET), .elem(P0_ELEM),
        .repl(P0_REPL), .dirty(P0_DIRTY), .tag(P0_TAG));
    dcache_array_model #(.K(1'b1)) p1_inst (.en(P1_SET_EN), .set(P1_SET), .elem(P1_ELEM),
        .repl(P1_REPL), .dirty(P1_DIRTY), .tag(P1_TAG));
    function automatic logic [31:0] nxt(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED DEST_DATA expected %h seen %h", exp, got);
        end
    endtask
    task automatic results;
        $display("fail_count %0d checks %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Issue one request; a status read offers a tag read while busy when bit 12 of the value is set, which must be dropped
    task automatic op(input logic [31:0] v);
        logic [31:0] a;
        logic [4:0]  s;
        a = v + {{23{v[10]}}, v[10:4], 2'h0};
        s = a[10:6];
        STATUS_REQ <= v[0];
        TAG_REQ <= v[1] | !v[0];
        REQ_PORT <= v[2];
        GUARD_PRESENT <= v[3];
        GUARD_VALUE <= {v[31:1], v[11]};
        FIRST_SOURCE_OPERAND <= v;
        MODIFIER <= {v[10:4], 2'h0};
        if (!v[3] || v[11])
            q.push_back(v[0] ? {14'h0, {3'h2, s} ^ {8{v[2]}}, {s, s} ^ {10{v[2]}}} : {10'h0, v[2], 3'h0, a[13:11], s, s, s});
        @(posedge CLK);
        if (v[0]) begin
            STATUS_REQ <= 1'b0;
            TAG_REQ <= v[12];
            repeat (3) @(posedge CLK);
        end
    endtask
    always @(posedge CLK) begin
        if (DEST_WE === 1'b1)
            cmp(q.size() > 0 ? q.pop_front() : 32'hxxxx_xxxx, DEST_DATA);
    end
    initial begin
        repeat (6) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        repeat (300) begin
            r = nxt(r);
            op(r);
        end
        STATUS_REQ <= 1'b0;
        TAG_REQ <= 1'b0;
        repeat (5) @(posedge CLK);
        cmp(32'h0, 32'(q.size()));
        results();
    end
    initial begin
        #30000;
        fail_count++;
        results();
    end
endmodule
